// [common/ptg_consts.vh]
// Constants for the four-channel pulse train generator.
// Assumes a 32-bit APB slave with one register per aligned word; channel and control registers are bytes.
`ifndef PTG_CONSTS_VH
`define PTG_CONSTS_VH
// Register byte addresses, per channel block of four words
`define PTG_CH_STRIDE      8'h10
`define PTG_OFF_PRL        8'h00
`define PTG_OFF_PRH        8'h04
`define PTG_OFF_CTL        8'h08
`define PTG_OFF_CTH        8'h0c
// Control pair registers, global enable and status vector
`define PTG_ADDR_CTRL_LO   8'h40
`define PTG_ADDR_CTRL_HI   8'h44
`define PTG_ADDR_GLOBAL    8'h48
`define PTG_ADDR_STATUS    8'h4c
// Channel word decode
`define PTG_OFF_MASK       8'h0c
`define PTG_CH_IDX_MSB     5
`define PTG_CH_IDX_LSB     4
// Global register fields
`define PTG_GLB_IEN        0
`define PTG_GLB_DIR_MSB    7
`define PTG_GLB_DIR_LSB    4
`define PTG_GLB_LVL_LSB    8
// Control nibble layout
`define PTG_BIT_RUN        0
`define PTG_BIT_IEN        1
`define PTG_BIT_PND        2
`define PTG_BIT_TM         3
`define PTG_NIB_W          4
// Interrupt vector address of the shared counter vector
`define PTG_IRQ_VECTOR     16'h00f0
`endif

// [logic/ptg_top.v]
// Four-channel pulse train generator with an APB register slave.
// Assumes clk is the instruction-cycle clock; software presets out levels.
// Assumes APB transfers with no wait states; reload bytes are never reset.
// Assumes software keeps the test-path bits at zero in normal operation.
// Assumes the far side reads the pins only while they are driven.
//
// Behaviour
// R1: Output high and low each one half-width
// R2: Sixteen-bit reload gives 1 to 65536 cycles
// R3: Setting run loads prescaler from reload bytes
// R4: Pulse count is count value plus one
// R5: All channel requests share one vector
// R6: Run write clears divider, reloads, starts counting
// R7: Prescaler decrements every clock while running
// R8: Underflow toggles pin and reloads prescaler
// R9: Every second underflow decrements count register
// R10: Count underflow clears run, sets pending, interrupts
// R11: Clearing run freezes count and pin
// R12: Restart gives full half-width before toggle
// R13: Software sets pin direction and start level
// R14: Pin level held in port data bit
// R15: Reset clears control bits and divider
// R16: Reset leaves reload bytes unchanged
// R17: Software loads reloads before setting run
// R18: Software handles underflow racing a stop
// R19: Interrupt needs channel and global enable
// R20: Pending stays until software clears it
// R21: Control byte holds two channel nibbles
// R22: Software never sets test-path bit
// R23: Four identical channels with byte reload registers
`timescale 1ns/1ps
`include "ptg_consts.vh"

module ptg_top #(
  parameter N_CH = 4,
  parameter PW   = 16
) (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Channel port pins
  output reg  [3:0]  pulse_out,
  output reg  [3:0]  pulse_out_en_n,
  // Shared counter interrupt
  output reg         counter_irq
);

  // Register map, byte addresses:
  //   channel n at n*10h: reload low, reload high, count low, count high
  //   40h: control nibbles of channels 0 and 1
  //   44h: control nibbles of channels 2 and 3
  //   48h: global enable, pin direction, pin levels
  //   4ch: shared counter vector, read only
  //   unmapped addresses read zero, writes are ignored
  // Control nibble: run, irq enable, irq pending, test path
  // Half-width of a channel is its reload value plus one clock.
  // Pulses per run are the count value plus one.
  // The count is left at all ones after a finished run.
  // Bus answers carry no wait state and no error.

  // Bus phase decode
  // Writes commit in the access phase; reads are sampled in setup
  wire          wr_acc = psel & penable & pwrite;
  wire          rd_acc = psel & penable & ~pwrite;
  wire          ch_sel = (paddr < `PTG_ADDR_CTRL_LO);
  wire [1:0]    ch_idx = paddr[`PTG_CH_IDX_MSB:`PTG_CH_IDX_LSB];
  wire [7:0]    ch_off = paddr & `PTG_OFF_MASK;

  // Global registers
  reg           global_irq_enable_q;
  reg  [3:0]    port_dir_q;          // 1 = pin driven as output (see R13)

  // Per-channel state flattened for the bus mux
  wire [4*8-1:0]  prl_w;
  wire [4*8-1:0]  prh_w;
  wire [4*8-1:0]  ctl_w;
  wire [4*8-1:0]  cth_w;
  wire [4*4-1:0]  nib_w;
  wire [3:0]      irq_w;
  wire [3:0]      out_w;

  // Bus answer flops: never a wait state, never an error
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end
  end

  // One channel per loop pass. Each holds:
  //   reload and count bytes, kept over a block reset
  //   a sixteen-bit prescaler loaded on a run write or on underflow
  //   a divide-by-two stage that steps the count once per pulse
  //   the control nibble and the pin level
  //   the interrupt request of the channel
  // Pulse widths and counts of the channels are independent.
  // A run write and a same-cycle underflow both reload the prescaler;
  // a stop write in the cycle of an underflow lets that toggle happen.
  genvar g;
  generate
    for (g = 0; g < N_CH; g = g + 1) begin : gen_ch
      reg [7:0]     prescale_reload_low_q;
      reg [7:0]     prescale_reload_high_q;
      reg [7:0]     pulse_count_low_q;
      reg [7:0]     pulse_count_high_q;
      reg [PW-1:0]  presc_q;
      reg           half_q;
      reg           channel_run_q;
      reg           channel_irq_enable_q;
      reg           channel_irq_pending_q;
      reg           channel_test_path_q;
      reg           level_q;
      wire [7:0]    ctrl_addr = (g < 2) ? `PTG_ADDR_CTRL_LO : `PTG_ADDR_CTRL_HI;
      wire          nsel      = ((g % 2) == 1);
      wire [3:0]    wnib      = nsel ? pwdata[7:4] : pwdata[3:0];
      wire          ctrl_wr   = wr_acc & (paddr == ctrl_addr);
      wire          reg_wr    = wr_acc & ch_sel & (ch_idx == g);
      wire          run_set   = ctrl_wr & wnib[`PTG_BIT_RUN];
      wire          prescale_underflow  = channel_run_q & (presc_q == {PW{1'b0}});
      wire          half_rate_underflow = prescale_underflow & half_q;
      wire          count_underflow     = half_rate_underflow &
                                          ({pulse_count_high_q, pulse_count_low_q} == 16'h0000);

      // Prescaler reload bytes, no reset so contents survive block reset (see R16, R23)
      always @(posedge clk) begin
        if (reg_wr && ch_off == `PTG_OFF_PRL) prescale_reload_low_q <= pwdata[7:0];
        if (reg_wr && ch_off == `PTG_OFF_PRH) prescale_reload_high_q <= pwdata[7:0];
      end

      // Count low byte, one step per output pulse (see R9, R4, R16)
      always @(posedge clk) begin
        if (reg_wr && ch_off == `PTG_OFF_CTL) begin
          pulse_count_low_q <= pwdata[7:0];
        end else if (half_rate_underflow) begin
          pulse_count_low_q <= pulse_count_low_q - 8'h01;       // see R9, R4
        end
      end

      // Count high byte, borrows when the low byte wraps (see R9)
      always @(posedge clk) begin
        if (reg_wr && ch_off == `PTG_OFF_CTH) begin
          pulse_count_high_q <= pwdata[7:0];
        end else if (half_rate_underflow && pulse_count_low_q == 8'h00) begin
          pulse_count_high_q <= pulse_count_high_q - 8'h01;     // see R9
        end
      end

      // Load on start or reload on underflow, else count down (see R3, R6, R7, R8, R12)
      always @(posedge clk) begin
        if (run_set || prescale_underflow) begin
          presc_q <= {prescale_reload_high_q, prescale_reload_low_q}; // see R2
        end else if (channel_run_q) begin
          presc_q <= presc_q - {{(PW-1){1'b0}}, 1'b1};
        end
      end

      // Divide-by-two stage, cleared by reset and by a run write (see R15, R6, R9)
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          half_q <= 1'b0;
        end else if (run_set) begin
          half_q <= 1'b0;                                        // see R6
        end else if (prescale_underflow) begin
          half_q <= ~half_q;                                     // see R9
        end
      end

      // Enable and test-path bits of the control nibble (see R15, R21)
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          channel_irq_enable_q <= 1'b0;
          channel_test_path_q  <= 1'b0;
        end else if (ctrl_wr) begin
          channel_irq_enable_q <= wnib[`PTG_BIT_IEN];
          channel_test_path_q  <= wnib[`PTG_BIT_TM];
        end
      end

      // Underflow stops channel; stop write freezes it (see R10, R11, R15)
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          channel_run_q <= 1'b0;
        end else if (count_underflow) begin
          channel_run_q <= 1'b0;
        end else if (ctrl_wr) begin
          channel_run_q <= wnib[`PTG_BIT_RUN];
        end
      end

      // Set wins over a clearing write; only software clears (see R10, R20, R15)
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          channel_irq_pending_q <= 1'b0;
        end else if (count_underflow) begin
          channel_irq_pending_q <= 1'b1;
        end else if (ctrl_wr) begin
          channel_irq_pending_q <= wnib[`PTG_BIT_PND];
        end
      end

      // Port data bit holds the level; software rewrites it (see R14, R8)
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          level_q <= 1'b0;
        end else if (wr_acc && paddr == `PTG_ADDR_GLOBAL) begin
          level_q <= pwdata[`PTG_GLB_LVL_LSB + g];
        end else if (prescale_underflow) begin
          level_q <= ~level_q;                                   // see R1
        end
      end

      assign prl_w[g*8 +: 8] = prescale_reload_low_q;
      assign prh_w[g*8 +: 8] = prescale_reload_high_q;
      assign ctl_w[g*8 +: 8] = pulse_count_low_q;
      assign cth_w[g*8 +: 8] = pulse_count_high_q;
      assign nib_w[g*4 +: 4] = {channel_test_path_q, channel_irq_pending_q,
                                channel_irq_enable_q, channel_run_q};
      assign irq_w[g]        = channel_irq_pending_q & channel_irq_enable_q;
      assign out_w[g]        = level_q;
    end
  endgenerate

  // Global enable and pin direction register
  // Pin levels are written here and read back from the channel levels
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      global_irq_enable_q <= 1'b0;
      port_dir_q          <= 4'h0;
    end else if (wr_acc && paddr == `PTG_ADDR_GLOBAL) begin
      global_irq_enable_q <= pwdata[`PTG_GLB_IEN];
      port_dir_q          <= pwdata[`PTG_GLB_DIR_MSB:`PTG_GLB_DIR_LSB];
    end
  end

  // Pin levels, one clock behind the channel levels (see R14, R1)
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pulse_out <= 4'h0;
    end else begin
      pulse_out <= out_w;
    end
  end

  // Pin enables, low while a pin is driven; all released in reset (see R13, R15)
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pulse_out_en_n <= 4'hf;
    end else begin
      pulse_out_en_n <= ~port_dir_q;
    end
  end

  // Single shared request for all channels (see R5, R19)
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      counter_irq <= 1'b0;
    end else begin
      counter_irq <= global_irq_enable_q & (|irq_w);
    end
  end

  // Read data mux, registered in the setup phase
  // Channel words show the byte in bits 7:0, upper bits read zero;
  // unmapped addresses read zero as well.
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    if (ch_sel) begin
      case (ch_off)
        `PTG_OFF_PRL: rd_d[7:0] = prl_w[ch_idx*8 +: 8];
        `PTG_OFF_PRH: rd_d[7:0] = prh_w[ch_idx*8 +: 8];
        `PTG_OFF_CTL: rd_d[7:0] = ctl_w[ch_idx*8 +: 8];
        default:      rd_d[7:0] = cth_w[ch_idx*8 +: 8];
      endcase
    end else begin
      case (paddr)
        `PTG_ADDR_CTRL_LO: rd_d[7:0]  = nib_w[7:0];
        `PTG_ADDR_CTRL_HI: rd_d[7:0]  = nib_w[15:8];
        `PTG_ADDR_GLOBAL:  rd_d[11:0] = {out_w, port_dir_q, 3'h0, global_irq_enable_q};
        `PTG_ADDR_STATUS:  rd_d[15:0] = `PTG_IRQ_VECTOR;
        default:           rd_d       = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

endmodule

// [verification/ptg_pin_model.sv]
// Pin-side observer: counts level changes of driven pins and the gap between them.
// Assumes pins change only on the block clock; undriven pins are ignored.
`timescale 1ns/1ps
module ptg_pin_model (
  // Pins seen from outside
  input  logic       clk,
  input  logic [3:0] pin,
  input  logic [3:0] pin_en_n,
  // Measurements
  output int         tog [4],
  output int         gap [4]
);
  int         tog_q [4] = '{default: 0};
  int         gap_q [4] = '{default: 0};
  int         c [4] = '{default: 0};
  logic [3:0] last_q = 4'h0;
  assign tog = tog_q;
  assign gap = gap_q;
  // Gap counts clocks since the previous change of a driven pin
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      c[i] <= c[i] + 1;
      if (!pin_en_n[i] && pin[i] !== last_q[i]) begin
        tog_q[i] <= tog_q[i] + 1;
        gap_q[i] <= c[i] + 1;
        c[i] <= 0;
      end
    end
    last_q <= pin;
  end
endmodule

// [verification/ptg_monitor.sv]
// Port checker for the pulse train generator.
// Assumes a single clock domain and the APB map of the block.
`timescale 1ns/1ps
module ptg_monitor (
  input logic        clk, resetn, psel, penable, pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata, prdata,
  input logic        pready, pslverr,
  input logic [3:0]  pulse_out, pulse_out_en_n,
  input logic        counter_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Committed write and read setup
  wire wr = psel & penable & pwrite;
  wire rs = psel & !penable & !pwrite;
  a_ready_fixed: assert property (pready && !pslverr) else $error("bus answer wrong");
  a_vector_read: assert property (rs && paddr == 8'h4c |=> prdata == 32'h00f0) else $error("vector wrong");
  a_unmapped_zero: assert property (rs && paddr == 8'h50 |=> prdata == 32'h0) else $error("hole not zero");
  a_reset_idle: assert property (disable iff (1'b0) !resetn ##1 !resetn |-> pulse_out_en_n == 4'hf && !counter_irq)
    else $error("reset state wrong");
  a_irq_global_off: assert property (wr && paddr == 8'h48 && !pwdata[0] |=> ##1 !counter_irq)
    else $error("irq without global enable");
  a_irq_holds: assert property (counter_irq && !$past(wr) |=> counter_irq) else $error("irq dropped");
  a_level_write: assert property (wr && paddr == 8'h48 |=> ##1 pulse_out == $past(pwdata[11:8], 2))
    else $error("pin level not set");
  a_stop_freeze: assert property (wr && paddr == 8'h40 && !pwdata[0] && !pwdata[4]
    |=> ##2 $stable(pulse_out[1:0]) [*4]) else $error("pin moved after stop");
  c_irq: cover property ($rose(counter_irq));
  c_run_ch1: cover property (wr && paddr == 8'h40 && pwdata[4]);
  c_vector: cover property (rs && paddr == 8'h4c);
endmodule
bind ptg_top ptg_monitor u_mon (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .pulse_out, .pulse_out_en_n, .counter_irq);

// [verification/tb_top.sv]
// Bench: APB master tasks drive the generator, a pin model measures outputs.
// Assumes ptg_top answers every transfer and clk runs at 10 MHz.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, counter_irq;
  logic [3:0]  pulse_out, pulse_out_en_n;
  int          tog [4], gap [4], n_errors = 0, total_checks = 0, cyc = 0, b;
  int          chs [3] = '{0, 2, 3};
  always #50 clk = ~clk;
  ptg_top i_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pulse_out, .pulse_out_en_n, .counter_irq);
  ptg_pin_model i_pin (.clk, .pin(pulse_out), .pin_en_n(pulse_out_en_n), .tog, .gap);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer, released only after pready is seen
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1, a, d, r);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(0, a, 0, r);
    chk(r, e);
  endtask
  // Reload and count bytes, low before high
  task setup(input logic [7:0] a, input logic [15:0] p, input logic [15:0] c);
    wr(a, {24'h0, p[7:0]});
    wr(a + 8'h4, {24'h0, p[15:8]});
    wr(a + 8'h8, {24'h0, c[7:0]});
    wr(a + 8'hc, {24'h0, c[15:8]});
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1;
    wr(8'h48, 32'h2f0);
    foreach (chs[j]) setup(8'(chs[j] * 16), 16'(chs[j]), 16'(chs[j]));
    wr(8'h40, 32'h03);
    wr(8'h44, 32'h33);
    repeat (60) @(negedge clk);
    foreach (chs[j]) begin
      chk(tog[chs[j]], 2 * chs[j] + 2);
      chk(gap[chs[j]], chs[j] + 1);
    end
    rd(8'h44, 32'h66);
    chk(counter_irq, 0);
    wr(8'h48, 32'h2f1);
    repeat (2) @(negedge clk);
    chk(counter_irq, 1);
    rd(8'h40, 32'h06);
    rd(8'h4c, 32'h00f0);
    rd(8'h50, 32'h0);
    rd(8'h0c, 32'hff);
    wr(8'h40, 32'h02);
    wr(8'h44, 32'h22);
    repeat (2) @(negedge clk);
    chk(counter_irq, 0);
    $display("test pulse trains done");
    setup(8'h10, 16'h5, 16'h5);
    b = tog[1];
    wr(8'h40, 32'h10);
    while (tog[1] - b < 4) @(negedge clk);
    wr(8'h40, 32'h0);
    repeat (30) @(negedge clk);
    chk(tog[1] - b, 4);
    chk(pulse_out[1], 1);
    wr(8'h40, 32'h10);
    repeat (80) @(negedge clk);
    chk(tog[1] - b, 12);
    chk(gap[1], 6);
    rd(8'h40, 32'h40);
    chk(counter_irq, 0);
    $display("test stop and restart done");
    wr(8'h40, 32'h01);
    @(posedge clk) resetn <= 0;
    repeat (2) @(negedge clk);
    chk(pulse_out_en_n, 4'hf);
    @(posedge clk) resetn <= 1;
    rd(8'h40, 32'h0);
    rd(8'h30, 32'h03);
    rd(8'h3c, 32'hff);
    $display("test reset done");
    test_done;
  end
endmodule
